//--- bbt_core.sv
/*
 * Execution and cycle timing of the bit-manipulation and branch
 * instruction groups: fetch, decode, condition test, write-back.
 * Assumes a program memory that answers pm_addr in the same cycle,
 * a data memory with same-cycle read and write at the clock edge,
 * and accumulator, data pointer and bank select held elsewhere.
 */
`timescale 1ns/1ps
`include "bbt_consts.svh"

module bbt_core
   import bbt_pkg::*;
#(
   parameter logic [15:0] RESET_ADDR = `BBT_RESET_PC
)
(
   input  logic        clk,
   input  logic        reset_n,
   output logic [15:0] pm_addr,
   input  logic [7:0]  pm_data,
   input  bbt_arch_t   arch,
   output logic        rd_en,
   output logic [7:0]  rd_addr,
   input  logic [7:0]  rd_data,
   output bbt_wr_t     wr,
   output logic        carry,
   output bbt_retire_t retire,
   output logic        unsupported_op
);

   bbt_state_t  s;
   bbt_state_t  next_s;
   bbt_dec_t    d;
   bbt_kind_t   k;
   logic [7:0]  op_now;
   logic [7:0]  bit_src;
   logic [7:0]  bit_byte;
   logic [2:0]  bit_idx;
   logic [7:0]  mask;
   logic [7:0]  dec_val;
   logic [15:0] seq;
   logic [15:0] rel_tgt;
   logic [15:0] ind_tgt;
   logic        fetch;
   logic        eval;
   logic        done;
   logic        rbit;
   logic        tk;
   logic        cy;

   function automatic bbt_dec_t decode(input logic [7:0] op);
      bbt_dec_t r;
      r = '{`BBT_LEN_1, `BBT_CYC_1, 1'h0, K_BAD};
      case (op)
         `BBT_OP_NOP:       r.kind = K_NOP;
         `BBT_OP_CLR_C:     r.kind = K_CLRC;
         `BBT_OP_SET_C:     r.kind = K_SETCY;
         `BBT_OP_CPL_C:     r.kind = K_CPLC;
         `BBT_OP_CLR_B:     r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_CLRB};
         `BBT_OP_SET_B:     r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_SETBIT};
         `BBT_OP_CPL_B:     r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_CPLB};
         `BBT_OP_AND_BIT:   r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_AND};
         `BBT_OP_AND_NBIT:  r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_ANDN};
         `BBT_OP_OR_BIT:    r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_OR};
         `BBT_OP_OR_NBIT:   r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_ORN};
         `BBT_OP_MOV_CB:    r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_MOVCB};
         `BBT_OP_MOV_BC:    r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h0, K_MOVBC};
         `BBT_OP_BR_CY:     r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h1, K_BRCY};
         `BBT_OP_BR_NCY:    r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h1, K_BRNCY};
         `BBT_OP_BR_B1:     r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_BRB1};
         `BBT_OP_BR_B0:     r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_BRB0};
         `BBT_OP_BR_BCLR:   r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_BRBCLR};
         `BBT_OP_SHORT_JMP: r = '{`BBT_LEN_2, `BBT_CYC_3, 1'h0, K_SJ};
         `BBT_OP_IND_JMP:   r = '{`BBT_LEN_1, `BBT_CYC_3, 1'h0, K_IJ};
         `BBT_OP_BR_AZ:     r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h1, K_BRAZ};
         `BBT_OP_BR_ANZ:    r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h1, K_BRANZ};
         `BBT_OP_CMP_AD:    r = '{`BBT_LEN_3, `BBT_CYC_4, 1'h1, K_CMPAD};
         `BBT_OP_CMP_AI:    r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_CMPAI};
         `BBT_OP_DEC_D:     r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_DECD};
         default: begin
            if (op[7:3] == `BBT_OP_CMP_RN_HI) begin
               r = '{`BBT_LEN_3, `BBT_CYC_3, 1'h1, K_CMPRN};
            end else if (op[7:1] == `BBT_OP_CMP_RI_HI) begin
               r = '{`BBT_LEN_3, `BBT_CYC_4, 1'h1, K_CMPRI};
            end else if (op[7:3] == `BBT_OP_DEC_RN_HI) begin
               r = '{`BBT_LEN_2, `BBT_CYC_2, 1'h1, K_DECRN};
            end
         end
      endcase
      return r;
   endfunction : decode

   // Opcode is live on the bus in the first cycle, held afterwards
   assign op_now  = (s.cnt == `BBT_CNT_ZERO) ? pm_data : s.op;
   assign d       = decode(op_now);
   assign k       = d.kind;
   assign fetch   = (s.phase == PH_FETCH);
   assign eval    = fetch && ((s.cnt + `BBT_CNT_ONE) == {1'h0, d.len});

   // Two-byte bit operations test the bit address still on the bus
   assign bit_src = (s.cnt == `BBT_CNT_ONE) ? pm_data : s.b1;

   bbt_bit_locate u_locate (
      .bit_addr  (bit_src),
      .byte_addr (bit_byte),
      .bit_idx   (bit_idx)
   );

   assign mask    = `BBT_BIT_ONE << bit_idx;
   assign rbit    = |(rd_data & mask);
   assign dec_val = rd_data - `BBT_BIT_ONE;
   assign seq     = s.fptr + `BBT_PC_STEP;
   assign rel_tgt = seq + 16'($signed(pm_data));
   assign ind_tgt = arch.data_pointer + {`BBT_BYTE_ZERO, arch.acc};

   // Data read port
   always_comb begin
      rd_en   = 1'h0;
      rd_addr = bit_byte;
      case (k)
         K_AND, K_ANDN, K_OR, K_ORN, K_MOVCB, K_MOVBC, K_CLRB, K_SETBIT,
         K_CPLB, K_BRB1, K_BRB0, K_BRBCLR: begin
            rd_en = eval;
         end
         K_CMPAD, K_DECD: begin
            rd_en   = eval;
            rd_addr = s.b1;
         end
         K_CMPRN, K_DECRN: begin
            rd_en   = eval;
            rd_addr = {`BBT_RBANK_PAD, arch.bank, op_now[2:0]};
         end
         K_CMPRI: begin
            // Pointer register first, then the byte it points at
            rd_en   = eval || (s.cnt == `BBT_CNT_ONE);
            rd_addr = eval ? s.ptr : {`BBT_RBANK_PAD, arch.bank, `BBT_RI_PAD, op_now[0]};
         end
         default: begin
            rd_en = 1'h0;
         end
      endcase
   end

   // Next state
   always_comb begin
      next_s        = s;
      next_s.wr.en  = 1'h0;
      next_s.ret.valid = 1'h0;
      next_s.bad    = 1'h0;
      tk            = 1'h0;
      cy            = s.carry;
      done          = 1'h0;
      if (fetch) begin
         next_s.fptr = seq;
         if (s.cnt == `BBT_CNT_ZERO) begin
            next_s.op = pm_data;
         end
         if (s.cnt == `BBT_CNT_ONE) begin
            next_s.b1 = pm_data;
            if (k == K_CMPRI) begin
               next_s.ptr = rd_data;
            end
         end
      end
      if (eval) begin
         next_s.target  = rel_tgt;
         next_s.wr.addr = rd_addr;
         next_s.wr.data = rd_data;
         case (k)
            K_AND:    cy = s.carry & rbit;
            K_ANDN:   cy = s.carry & ~rbit;
            K_OR:     cy = s.carry | rbit;
            K_ORN:    cy = s.carry | ~rbit;
            K_MOVCB:  cy = rbit;
            K_MOVBC: begin
               next_s.wr.en   = 1'h1;
               next_s.wr.data = (rd_data & ~mask) | (s.carry ? mask : `BBT_BYTE_ZERO);
            end
            K_CLRC:   cy = 1'h0;
            K_SETCY:  cy = 1'h1;
            K_CPLC:   cy = ~s.carry;
            K_CLRB: begin
               next_s.wr.en   = 1'h1;
               next_s.wr.data = rd_data & ~mask;
            end
            K_SETBIT: begin
               next_s.wr.en   = 1'h1;
               next_s.wr.data = rd_data | mask;
            end
            K_CPLB: begin
               next_s.wr.en   = 1'h1;
               next_s.wr.data = rd_data ^ mask;
            end
            K_BRCY:   tk = s.carry;
            K_BRNCY:  tk = ~s.carry;
            K_BRB1:   tk = rbit;
            K_BRB0:   tk = ~rbit;
            K_BRBCLR: begin
               tk             = rbit;
               next_s.wr.en   = rbit;
               next_s.wr.data = rd_data & ~mask;
            end
            K_SJ:     tk = 1'h1;
            K_IJ: begin
               tk            = 1'h1;
               next_s.target = ind_tgt;
            end
            K_BRAZ:   tk = (arch.acc == `BBT_BYTE_ZERO);
            K_BRANZ:  tk = (arch.acc != `BBT_BYTE_ZERO);
            K_CMPAD: begin
               tk = (arch.acc != rd_data);
               cy = (arch.acc < rd_data);
            end
            K_CMPAI: begin
               tk = (arch.acc != s.b1);
               cy = (arch.acc < s.b1);
            end
            K_CMPRN, K_CMPRI: begin
               tk = (rd_data != s.b1);
               cy = (rd_data < s.b1);
            end
            K_DECRN, K_DECD: begin
               tk             = (dec_val != `BBT_BYTE_ZERO);
               next_s.wr.en   = 1'h1;
               next_s.wr.data = dec_val;
            end
            default: begin
               tk = 1'h0;
            end
         endcase
         next_s.carry = cy;
         next_s.taken = tk;
         next_s.need  = d.base + 3'(d.cond & tk);
         next_s.phase = PH_WAIT;
      end
      // Finish on the last counted cycle of the instruction
      if (eval) begin
         done = ((s.cnt + `BBT_CNT_ONE) == next_s.need);
      end else begin
         done = (s.phase == PH_WAIT) && ((s.cnt + `BBT_CNT_ONE) == s.need);
      end
      next_s.cnt = s.cnt + `BBT_CNT_ONE;
      if (done) begin
         next_s.cnt        = `BBT_CNT_ZERO;
         next_s.phase      = PH_FETCH;
         if (next_s.taken) begin
            next_s.fptr = next_s.target;
         end
         next_s.ret.valid  = 1'h1;
         next_s.ret.opcode = op_now;
         next_s.ret.len    = d.len;
         next_s.ret.cycles = s.cnt + `BBT_CNT_ONE;
         next_s.ret.taken  = next_s.taken;
         next_s.r_kind     = k;
         next_s.bad        = (k == K_BAD);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{phase: PH_FETCH, fptr: RESET_ADDR, r_kind: K_NOP, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign pm_addr        = s.fptr;
   assign wr             = s.wr;
   assign carry          = s.carry;
   assign retire         = s.ret;
   assign unsupported_op = s.bad;

   // Checks
   logic [2:0] gap;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap <= `BBT_CNT_ZERO;
      end else begin
         gap <= s.ret.valid ? `BBT_CNT_ONE : gap + `BBT_CNT_ONE;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_ret(kset);
      s.ret.valid && kset;
   endsequence

   property p_time(kset, ln, base, cd);
      s_ret(kset) |-> (retire.len == ln) &&
                      (retire.cycles == base + 3'(cd && retire.taken));
   endproperty

   sequence s_rel_taken;
      eval && tk && (k inside {K_BRCY, K_BRNCY, K_BRB1, K_BRB0, K_BRBCLR, K_SJ,
                               K_BRAZ, K_BRANZ, K_CMPAD, K_CMPAI, K_CMPRN,
                               K_CMPRI, K_DECRN, K_DECD});
   endsequence

   a_bit_logic_time:
      assert property (p_time(s.r_kind inside {K_AND, K_ANDN, K_OR, K_ORN, K_MOVCB, K_MOVBC},
                              `BBT_LEN_2, `BBT_CYC_2, 1'h0))
      else $error("bit logic length or cycles wrong");
   a_carry_br_time:
      assert property (p_time(s.r_kind inside {K_BRCY, K_BRNCY}, `BBT_LEN_2, `BBT_CYC_2, 1'h1))
      else $error("carry branch length or cycles wrong");
   a_bit_br_time:
      assert property (p_time(s.r_kind inside {K_BRB1, K_BRB0, K_BRBCLR},
                              `BBT_LEN_3, `BBT_CYC_3, 1'h1))
      else $error("bit branch length or cycles wrong");
   a_bit_clear_write:
      assert property ((eval && k == K_BRBCLR && rbit) |->
                       ##1 (wr.en && wr.addr == $past(rd_addr) && (wr.data & $past(mask)) == '0))
      else $error("tested bit not cleared");
   a_short_jmp_time:
      assert property (p_time(s.r_kind == K_SJ, `BBT_LEN_2, `BBT_CYC_3, 1'h0))
      else $error("short jump length or cycles wrong");
   a_ind_jmp_time:
      assert property (p_time(s.r_kind == K_IJ, `BBT_LEN_1, `BBT_CYC_3, 1'h0))
      else $error("indirect jump length or cycles wrong");
   a_ind_jmp_target:
      assert property ((eval && k == K_IJ) |-> ##3 (s.ret.valid && pm_addr == $past(ind_tgt, 3)))
      else $error("indirect jump target wrong");
   a_acc_br_time:
      assert property (p_time(s.r_kind inside {K_BRAZ, K_BRANZ}, `BBT_LEN_2, `BBT_CYC_2, 1'h1))
      else $error("accumulator branch length or cycles wrong");
   a_cmp_slow_time:
      assert property (p_time(s.r_kind inside {K_CMPAD, K_CMPRI}, `BBT_LEN_3, `BBT_CYC_4, 1'h1))
      else $error("slow compare length or cycles wrong");
   a_cmp_fast_time:
      assert property (p_time(s.r_kind inside {K_CMPAI, K_CMPRN}, `BBT_LEN_3, `BBT_CYC_3, 1'h1))
      else $error("fast compare length or cycles wrong");
   a_dec_reg_time:
      assert property (p_time(s.r_kind == K_DECRN, `BBT_LEN_2, `BBT_CYC_2, 1'h1))
      else $error("register decrement length or cycles wrong");
   a_dec_dir_time:
      assert property (p_time(s.r_kind == K_DECD, `BBT_LEN_3, `BBT_CYC_3, 1'h1))
      else $error("direct decrement length or cycles wrong");
   a_gap_cycles:
      assert property (s.ret.valid |-> gap == retire.cycles)
      else $error("retire spacing differs from reported cycles");
   logic [15:0] rel_latch;

   // Expected target: byte after the displacement plus the signed displacement
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rel_latch <= `BBT_RESET_PC;
      end else if (eval) begin
         rel_latch <= pm_addr + `BBT_PC_STEP + 16'($signed(pm_data));
      end
   end

   a_rel_target:
      assert property (s_rel_taken |-> ##[2:3] (s.ret.valid && pm_addr == rel_latch))
      else $error("relative branch target wrong");

endmodule : bbt_core

//--- bbt_consts.svh
/*
 * Constants for the bit-manipulation and branch timing block:
 * opcode encodings, instruction lengths, cycle counts and reset values.
 * Assumes inclusion by bare name from each design file that uses its macros.
 */
`ifndef BBT_CONSTS_SVH
`define BBT_CONSTS_SVH

// Opcode encodings
`define BBT_OP_NOP        8'h00
`define BBT_OP_AND_BIT    8'h82
`define BBT_OP_AND_NBIT   8'hb0
`define BBT_OP_OR_BIT     8'h72
`define BBT_OP_OR_NBIT    8'ha0
`define BBT_OP_MOV_CB     8'ha2
`define BBT_OP_MOV_BC     8'h92
`define BBT_OP_CLR_C      8'hc3
`define BBT_OP_CLR_B      8'hc2
`define BBT_OP_SET_C      8'hd3
`define BBT_OP_SET_B      8'hd2
`define BBT_OP_CPL_C      8'hb3
`define BBT_OP_CPL_B      8'hb2
`define BBT_OP_BR_CY      8'h40
`define BBT_OP_BR_NCY     8'h50
`define BBT_OP_BR_B1      8'h20
`define BBT_OP_BR_B0      8'h30
`define BBT_OP_BR_BCLR    8'h10
`define BBT_OP_SHORT_JMP  8'h80
`define BBT_OP_IND_JMP    8'h73
`define BBT_OP_BR_AZ      8'h60
`define BBT_OP_BR_ANZ     8'h70
`define BBT_OP_CMP_AD     8'hb5
`define BBT_OP_CMP_AI     8'hb4
`define BBT_OP_DEC_D      8'hd5
`define BBT_OP_CMP_RI_HI  7'h5b
`define BBT_OP_CMP_RN_HI  5'h17
`define BBT_OP_DEC_RN_HI  5'h1b

// Instruction lengths in bytes
`define BBT_LEN_1         2'h1
`define BBT_LEN_2         2'h2
`define BBT_LEN_3         2'h3

// Base cycle counts; a taken conditional branch adds one
`define BBT_CYC_1         3'h1
`define BBT_CYC_2         3'h2
`define BBT_CYC_3         3'h3
`define BBT_CYC_4         3'h4

// Counters, address layout and reset values
`define BBT_CNT_ZERO      3'h0
`define BBT_CNT_ONE       3'h1
`define BBT_PC_STEP       16'h0001
`define BBT_RESET_PC      16'h0000
`define BBT_BYTE_ZERO     8'h00
`define BBT_BIT_ONE       8'h01
`define BBT_BIT_RAM_HI    4'h2
`define BBT_SFR_BIT_PAD   3'h0
`define BBT_RBANK_PAD     3'h0
`define BBT_RI_PAD        2'h0

`endif

//--- bbt_pkg.sv
/*
 * Types of the bit-manipulation and branch timing block.
 * Assumes nothing of its surroundings; included before all modules.
 */
package bbt_pkg;

   typedef enum logic [4:0] {
      K_NOP, K_AND, K_ANDN, K_OR, K_ORN, K_MOVCB, K_MOVBC,
      K_CLRC, K_CLRB, K_SETCY, K_SETBIT, K_CPLC, K_CPLB,
      K_BRCY, K_BRNCY, K_BRB1, K_BRB0, K_BRBCLR, K_SJ, K_IJ,
      K_BRAZ, K_BRANZ, K_CMPAD, K_CMPAI, K_CMPRI, K_CMPRN,
      K_DECRN, K_DECD, K_BAD
   } bbt_kind_t;

   typedef enum logic [1:0] {
      PH_FETCH = 2'h1,
      PH_WAIT  = 2'h2
   } bbt_phase_t;

   typedef struct packed {
      logic [1:0] len;
      logic [2:0] base;
      logic       cond;
      bbt_kind_t  kind;
   } bbt_dec_t;

   typedef struct packed {
      logic [7:0]  acc;
      logic [15:0] data_pointer;
      logic [1:0]  bank;
   } bbt_arch_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } bbt_wr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [1:0] len;
      logic [2:0] cycles;
      logic       taken;
   } bbt_retire_t;

   typedef struct packed {
      bbt_phase_t  phase;
      logic [2:0]  cnt;
      logic [2:0]  need;
      logic [15:0] fptr;
      logic [15:0] target;
      logic [7:0]  op;
      logic [7:0]  b1;
      logic [7:0]  ptr;
      logic        carry;
      logic        taken;
      bbt_wr_t     wr;
      bbt_retire_t ret;
      bbt_kind_t   r_kind;
      logic        bad;
   } bbt_state_t;

endpackage : bbt_pkg

//--- bbt_bit_locate.sv
/*
 * Maps a direct bit address to its byte address and bit position.
 * Assumes bit-addressable RAM from byte 0x20 and bit-addressable
 * registers on addresses ending in 0 or 8 above 0x80.
 */
`timescale 1ns/1ps
`include "bbt_consts.svh"

module bbt_bit_locate
   import bbt_pkg::*;
(
   input  logic [7:0] bit_addr,
   output logic [7:0] byte_addr,
   output logic [2:0] bit_idx
);

   // Upper half addresses registers, lower half the bit RAM
   assign byte_addr = bit_addr[7] ? {bit_addr[7:3], `BBT_SFR_BIT_PAD}
                                  : {`BBT_BIT_RAM_HI, bit_addr[6:3]};
   assign bit_idx   = bit_addr[2:0];

endmodule : bbt_bit_locate

//--- bbt_mem.sv
/* Program and data memory facing bbt_core.
   Assumes same-cycle reads and writes taken at the rising clock edge. */
`timescale 1ns/1ps

module bbt_mem
   import bbt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] pm_addr,
   output logic      [7:0]  pm_data,
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data,
   input  wire bbt_wr_t     wr
);
   logic [7:0] rom [65536];
   logic [7:0] ram [256];
   logic [7:0] last = 8'h00;

   assign pm_data = rom[pm_addr];
   // Idle data bus shows the inverse of the last byte read
   assign rd_data = rd_en ? ram[rd_addr] : ~last;

   always @(posedge clk) begin
      if (rd_en === 1'b1) last <= ram[rd_addr];
      if (wr.en === 1'b1) ram[wr.addr] <= wr.data;
   end
endmodule : bbt_mem

//--- tb.sv
/* Self-checking bench for bbt_core with a reference model.
   Assumes bbt_mem answers reads in the same cycle. */
`timescale 1ns/1ps

module tb
   import bbt_pkg::*;
;
   typedef struct {int op, ln, cyc, tk, nxt, cy, bad;} bbt_exp_t;
   localparam int OPS [28] = '{8'hc3, 8'hd3, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92, 8'h40, 8'h50, 8'h20,
                               8'h30, 8'h10, 8'h80, 8'h60, 8'h70, 8'hb5, 8'hb4, 8'hb8, 8'hb6, 8'hd8, 8'hd5,
                               8'hc2, 8'hd2, 8'hb2, 8'hb3, 8'h00, 8'ha5};
   localparam int LNS [28] = '{1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 2, 2, 2, 3, 3, 3, 3, 2, 3, 2, 2, 2, 1, 1, 1};
   localparam int BCS [28] = '{1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 2, 2, 4, 3, 3, 4, 2, 3, 2, 2, 2, 1, 1, 1};
   logic        clk     = 1'b0;
   logic        reset_n = 1'b0;
   bbt_arch_t   arch    = '0;
   logic [15:0] pm_addr;
   logic [7:0]  pm_data, rd_addr, rd_data;
   logic        rd_en, carry, unsupported_op;
   bbt_wr_t     wr;
   bbt_retire_t retire;
   int          err_count = 0, n_checks = 0, seed = 26142, cycles = 0, gap = 0, cy;
   int          ram [256];
   bbt_exp_t    q [$], e;

   always #50 clk = ~clk;

   bbt_core u_bbt_core (.clk(clk), .reset_n(reset_n), .pm_addr(pm_addr), .pm_data(pm_data), .arch(arch),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .wr(wr), .carry(carry), .retire(retire),
      .unsupported_op(unsupported_op));
   bbt_mem u_bbt_mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr(wr));

   task automatic check(input string what, input logic [15:0] seen, input int exp);
      n_checks++;
      if (seen !== 16'(exp)) begin
         err_count++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   // Builds a random program and predicts each retirement
   task automatic gen(input int n);
      int pc, k, a, b, r, x, y, g, d, by, msk, bt, m, v, tk, op;
      pc = 'h100;
      u_bbt_mem.rom[0] = 8'h73;
      q.push_back('{8'h73, 1, 3, -1, 16'h0100, 0, 0});
      for (int i = 0; i < n; i++) begin
         k = {$random(seed)} % 28;
         a = {$random(seed)} % 128;
         b = 'h30 + {$random(seed)} % 80;
         r = {$random(seed)} % 16;
         x = {$random(seed)} % 256;
         y = {$random(seed)} % 8;
         g = arch.bank * 8 + y;
         d = (k == 20) ? g : b;
         by = 32 + a / 8;
         msk = 1 << (a % 8);
         bt = (ram[by] & msk) != 0;
         m = arch.acc;
         v = x;
         tk = -1;
         op = OPS[k] + ((k == 18 || k == 20) ? y : (k == 19) ? y % 2 : 0);
         case (k)
            0, 1: cy = k;
            2: cy = cy & bt;
            3: cy = cy & !bt;
            4: cy = cy | bt;
            5: cy = cy | !bt;
            6: cy = bt;
            8: tk = cy;
            9: tk = !cy;
            10, 12: tk = bt;
            11: tk = !bt;
            14: tk = (m == 0);
            15: tk = (m != 0);
            16: v = ram[b];
            18: m = ram[g];
            19: m = ram[ram[arch.bank * 8 + y % 2]];
            25: cy = !cy;
            default: ;
         endcase
         if (k == 7 || k == 12) ram[by] = ram[by] & ~msk | ((k == 7 && cy) ? msk : 0);
         if (k >= 22 && k <= 24) ram[by] = (k == 22) ? ram[by] & ~msk : (k == 23) ? ram[by] | msk : ram[by] ^ msk;
         if (k >= 16 && k <= 19) begin
            tk = (m != v);
            cy = (m < v);
         end
         if (k == 20 || k == 21) begin
            ram[d] = (ram[d] + 255) % 256;
            tk = (ram[d] != 0);
         end
         u_bbt_mem.rom[pc] = 8'(op);
         u_bbt_mem.rom[pc + 1] = 8'((LNS[k] == 2 && k >= 8 && k <= 20) ? r : (k <= 12 || k >= 22) ? a :
                                    (k == 16 || k == 21) ? b : x);
         u_bbt_mem.rom[pc + 2] = 8'(r);
         pc += LNS[k] + ((tk == 1 || k == 13) ? r : 0);
         q.push_back('{op, LNS[k], BCS[k] + (tk == 1), tk, pc, cy, k == 27});
      end
   endtask : gen

   always @(posedge clk) begin
      cycles++;
      if (reset_n !== 1'b1) gap = 0;
      else gap++;
      if (cycles == 5000) begin
         err_count++;
         $display("FAIL timeout expected done seen running");
         test_done();
      end
      #1;
      if (reset_n === 1'b1 && retire.valid === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         check("opcode", 16'(retire.opcode), e.op);
         check("length", 16'(retire.len), e.ln); // to
         check("cycles", 16'(retire.cycles), e.cyc);
         check("spacing", 16'(gap), e.cyc);
         if (e.tk >= 0) check("taken", 16'(retire.taken), e.tk);
         check("next address", pm_addr, e.nxt);
         check("carry", 16'(carry), e.cy); // to
         check("unsupported", 16'(unsupported_op), e.bad);
         gap = 0;
      end
   end

   initial begin
      for (int p = 0; p < 2; p++) begin
         reset_n = 1'b0;
         arch.acc = (p == 0) ? 8'($random(seed)) : 8'h00;
         arch.bank = 2'($random(seed));
         arch.data_pointer = 16'h0100 - 16'(arch.acc);
         cy = 0;
         q.delete();
         for (int i = 0; i < 65536; i++) u_bbt_mem.rom[i] = 8'h00;
         for (int i = 0; i < 256; i++) begin
            ram[i] = {$random(seed)} % 256;
            u_bbt_mem.ram[i] = 8'(ram[i]);
         end
         gen(150);
         repeat (5) @(posedge clk);
         #1;
         check("reset address", pm_addr, 0);
         check("reset carry", 16'(carry), 0);
         #4 reset_n = 1'b1;
         while (q.size() > 0) @(posedge clk);
         @(posedge clk);
         #5;
         for (int i = 0; i < 256; i++) begin
            check("ram byte", 16'(u_bbt_mem.ram[i]), ram[i]);
         end
         $display("Test pass %0d done, checks %0d", p, n_checks);
      end
      test_done();
   end
endmodule : tb
